// file: core/dram_ctrl_unit.sv
// Purpose: dram access and precharge control for up to four banks
// Assumes: bus addr width equals ROW_W+COL_W+2; mode bits static while busy
// Notes: refresh timing source is external (refresh_tick_i)
`timescale 1ns/10ps
`default_nettype none
`include "drc_params.svh"
module dram_ctrl_unit #(
  parameter int NUM_BANKS = 4,
  parameter int ROW_W = 10,
  parameter int COL_W = 10,
  parameter int DA_W = (ROW_W > COL_W) ? ROW_W : COL_W
) (
  input wire logic clock_i,                   // system clock
  input wire logic sys_rst_i,                 // sync reset, high
  drc_if.dev bus,                             // processor side
  input wire logic col_setup_select_i,        // column setup choice
  input wire logic row_hold_select_i,         // row hold choice
  input wire logic write_cas_delay_select_i,  // delay cas on writes
  input wire logic precharge_count_sel_lo_i,  // precharge field bit 0
  input wire logic precharge_count_sel_hi_i,  // precharge field bit 1
  input wire logic async_mode_select_i,       // 0 latch pulse, 1 strobe
  input wire logic refresh_tick_i,            // refresh interval elapsed
  output logic [NUM_BANKS-1:0] ras_n_o,       // row strobes
  output logic [NUM_BANKS-1:0] cas_n_o,       // column strobes
  output logic [DA_W-1:0] dram_addr_o,        // muxed dram address
  output logic dram_we_n_o                    // dram write enable
);
  drc_pkg::dev_state_e state_q;
  logic latch_prev_q;
  logic strobe_prev_q;
  logic [`DRC_BANK_W-1:0] bank_q;
  logic [ROW_W-1:0] row_q;
  logic [COL_W-1:0] col_q;
  logic [COL_W-1:0] col_d;
  logic write_q;
  logic [2:0] tcnt_q;
  logic delay_q;
  logic rfsh_pending_q;
  logic [ROW_W-1:0] rfsh_row_q;
  logic [DA_W-1:0] dram_addr_q;
  logic we_n_q;
  logic strobe_evt;
  logic open_evt;
  logic col_evt;
  logic [`DRC_BANK_W-1:0] new_bank;
  logic [NUM_BANKS-1:0] busy;
  logic [NUM_BANKS-1:0] release_vec;
  logic [2:0] pc_target;
  logic [2:0] row_hold_cyc;
  logic [2:0] col_setup_cyc;
  logic ras_active;
  logic rfsh_end;

  // bank index from the lowest address bits; upper bit ignored with two banks
  function automatic logic [`DRC_BANK_W-1:0] bank_of(input logic [ROW_W+COL_W+1:0] a);
    logic [`DRC_BANK_W-1:0] b;
    b = a[`DRC_BANK_LSB +: `DRC_BANK_W];
    return b & `DRC_BANK_W'(NUM_BANKS - 1);
  endfunction

  function automatic logic [DA_W-1:0] widen_row(input logic [ROW_W-1:0] r);
    return DA_W'(r);
  endfunction

  function automatic logic [DA_W-1:0] widen_col(input logic [COL_W-1:0] c);
    return DA_W'(c);
  endfunction

  assign pc_target = 3'({precharge_count_sel_hi_i, precharge_count_sel_lo_i}) +
    `DRC_PRECHARGE_BASE_CYC;
  assign row_hold_cyc = row_hold_select_i ? 3'(`DRC_ROW_HOLD_SEL1_CYC) :
    3'(`DRC_ROW_HOLD_SEL0_CYC);
  assign col_setup_cyc = col_setup_select_i ? 3'(`DRC_COL_SETUP_SEL1_CYC) :
    3'(`DRC_COL_SETUP_SEL0_CYC);

  // start protocol: latch pulse seen last edge, or falling strobe
  assign strobe_evt = async_mode_select_i ? (strobe_prev_q & ~bus.addr_strobe_n) :
    latch_prev_q;
  assign open_evt = strobe_evt & ~bus.chip_select_n & ~bus.access_request_n;
  assign col_evt = strobe_evt & bus.chip_select_n;
  assign new_bank = bank_of(bus.addr);
  assign ras_active = (state_q == drc_pkg::DEV_ROW) || (state_q == drc_pkg::DEV_COLSU) ||
    (state_q == drc_pkg::DEV_CAS);
  assign rfsh_end = (state_q == drc_pkg::DEV_RFSH) && (tcnt_q == 3'h1);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      latch_prev_q <= 1'b0;
      strobe_prev_q <= 1'b1;
    end else begin
      latch_prev_q <= bus.addr_latch;
      strobe_prev_q <= bus.addr_strobe_n;
    end
  end

  // precharge starts on the edge where the bank's ras goes high
  always_comb begin
    release_vec = '0;
    if (ras_active && bus.access_request_n) begin
      release_vec[bank_q] = 1'b1;
    end
    if (rfsh_end) begin
      release_vec = '1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
      bank_precharge_counter u_pc (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .start_i(release_vec[gi]),
        .target_i(pc_target),
        .busy_o(busy[gi])
      );
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= drc_pkg::DEV_IDLE;
      bank_q <= '0;
      row_q <= '0;
      write_q <= 1'b0;
      tcnt_q <= 3'h0;
      delay_q <= 1'b0;
    end else begin
      case (state_q)
        drc_pkg::DEV_IDLE: begin
          if (open_evt) begin
            bank_q <= new_bank;
            row_q <= bus.addr[`DRC_COL_LSB+COL_W +: ROW_W];
            write_q <= ~bus.write_n;
            tcnt_q <= row_hold_cyc;
            // interleave: only the addressed bank must be precharged
            state_q <= busy[new_bank] ? drc_pkg::DEV_WAIT : drc_pkg::DEV_ROW;
          end else if (rfsh_pending_q && bus.access_request_n && !(|busy)) begin
            tcnt_q <= 3'(`DRC_REFRESH_RAS_CYC);
            state_q <= drc_pkg::DEV_RFSH;
          end
        end
        drc_pkg::DEV_WAIT: begin
          if (bus.access_request_n) begin
            state_q <= drc_pkg::DEV_IDLE;
          end else if (!busy[bank_q]) begin
            state_q <= drc_pkg::DEV_ROW;
          end
        end
        drc_pkg::DEV_ROW: begin
          if (bus.access_request_n) begin
            state_q <= drc_pkg::DEV_IDLE;
          end else if (tcnt_q <= 3'h1) begin
            tcnt_q <= col_setup_cyc;
            state_q <= drc_pkg::DEV_COLSU;
          end else begin
            tcnt_q <= tcnt_q - 3'h1;
          end
        end
        drc_pkg::DEV_COLSU: begin
          if (bus.access_request_n) begin
            state_q <= drc_pkg::DEV_IDLE;
          end else if (tcnt_q <= 3'h1) begin
            delay_q <= write_q & write_cas_delay_select_i;
            tcnt_q <= 3'(`DRC_WRITE_CAS_DELAY_CYC);
            state_q <= drc_pkg::DEV_CAS;
          end else begin
            tcnt_q <= tcnt_q - 3'h1;
          end
        end
        drc_pkg::DEV_CAS: begin
          if (delay_q && tcnt_q <= 3'h1) begin
            delay_q <= 1'b0;
          end else if (delay_q) begin
            tcnt_q <= tcnt_q - 3'h1;
          end
          // row stays open while the request is held
          if (bus.access_request_n) begin
            state_q <= drc_pkg::DEV_IDLE;
          end
        end
        drc_pkg::DEV_RFSH: begin
          if (tcnt_q <= 3'h1) begin
            state_q <= drc_pkg::DEV_IDLE;
          end else begin
            tcnt_q <= tcnt_q - 3'h1;
          end
        end
        default: begin
          state_q <= drc_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // column pointer: strobed column or internal increment, no new ras
  always_comb begin
    col_d = col_q;
    if ((state_q == drc_pkg::DEV_IDLE && open_evt) || (ras_active && col_evt)) begin
      col_d = bus.addr[`DRC_COL_LSB +: COL_W];
    end else if (state_q == drc_pkg::DEV_CAS && bus.column_increment) begin
      col_d = col_q + COL_W'(1);
    end
  end

  // the address pins take the next column so it stands when cas falls again
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      col_q <= '0;
    end else begin
      col_q <= col_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dram_addr_q <= '0;
      we_n_q <= 1'b1;
    end else begin
      if (state_q == drc_pkg::DEV_IDLE && open_evt) begin
        dram_addr_q <= widen_row(bus.addr[`DRC_COL_LSB+COL_W +: ROW_W]);
      end else if (state_q == drc_pkg::DEV_IDLE) begin
        dram_addr_q <= widen_row(rfsh_row_q);
      end else if (state_q == drc_pkg::DEV_ROW && tcnt_q <= 3'h1) begin
        dram_addr_q <= widen_col(col_d);
      end else if (state_q == drc_pkg::DEV_CAS) begin
        dram_addr_q <= widen_col(col_d);
      end
      we_n_q <= ~(ras_active & write_q & ~bus.access_request_n);
    end
  end

  // a tick in the clearing cycle keeps the request pending
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rfsh_pending_q <= 1'b0;
      rfsh_row_q <= '0;
    end else begin
      if (refresh_tick_i) begin
        rfsh_pending_q <= 1'b1;
      end else if (rfsh_end) begin
        rfsh_pending_q <= 1'b0;
      end
      if (rfsh_end) begin
        rfsh_row_q <= rfsh_row_q + ROW_W'(1);
      end
    end
  end

  // cas gated straight by its enable; no tcp check between columns
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      ras_n_o[i] = ~((ras_active && bank_q == `DRC_BANK_W'(i)) || state_q == drc_pkg::DEV_RFSH);
      cas_n_o[i] = ~(state_q == drc_pkg::DEV_CAS && !delay_q && bank_q == `DRC_BANK_W'(i)) |
        bus.cas_enable_n[i];
    end
  end

  assign bus.wait_n = ~((state_q == drc_pkg::DEV_WAIT) || (state_q == drc_pkg::DEV_ROW) ||
    (state_q == drc_pkg::DEV_COLSU) || (state_q == drc_pkg::DEV_RFSH));
  assign bus.refresh_request_out = rfsh_pending_q;
  assign dram_addr_o = dram_addr_q;
  assign dram_we_n_o = we_n_q;
endmodule
`default_nettype wire

// file: core/drc_params.svh
// Purpose: timing counts and field positions shared by both ends of the dram access link
// Assumes: clock of 100 MHz; processor address = {row, column, bank}
// Notes: cycle counts derive from the printed times
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

`define DRC_CLK_PERIOD_NS 10
`define DRC_CYC_UP(ns) ((((ns) + `DRC_CLK_PERIOD_NS - 1) / `DRC_CLK_PERIOD_NS) > 0 ? \
  (((ns) + `DRC_CLK_PERIOD_NS - 1) / `DRC_CLK_PERIOD_NS) : 1)

`define DRC_COL_SETUP_SEL0_NS 10
`define DRC_COL_SETUP_SEL1_NS 0
`define DRC_ROW_HOLD_SEL0_NS 25
`define DRC_ROW_HOLD_SEL1_NS 15
`define DRC_COL_SETUP_SEL0_CYC `DRC_CYC_UP(`DRC_COL_SETUP_SEL0_NS)
`define DRC_COL_SETUP_SEL1_CYC `DRC_CYC_UP(`DRC_COL_SETUP_SEL1_NS)
`define DRC_ROW_HOLD_SEL0_CYC `DRC_CYC_UP(`DRC_ROW_HOLD_SEL0_NS)
`define DRC_ROW_HOLD_SEL1_CYC `DRC_CYC_UP(`DRC_ROW_HOLD_SEL1_NS)

`define DRC_WRITE_CAS_DELAY_CYC 1
`define DRC_PRECHARGE_BASE_CYC 3'h2
`define DRC_REFRESH_RAS_CYC 4
`define DRC_MIN_RAS_LOW_CYC 6
`define DRC_MAX_RAS_LOW_CYC 1000

`define DRC_BANK_LSB 0
`define DRC_BANK_W 2
`define DRC_COL_LSB 2

`endif

// file: core/drc_pkg.sv
// Purpose: state types for both ends of the dram access link
// Assumes: nothing beyond the params header
// Notes: one-hot codes written out
package drc_pkg;

  typedef enum logic [5:0] {
    DEV_IDLE  = 6'h01,
    DEV_WAIT  = 6'h02,
    DEV_ROW   = 6'h04,
    DEV_COLSU = 6'h08,
    DEV_CAS   = 6'h10,
    DEV_RFSH  = 6'h20
  } dev_state_e;

  typedef enum logic [5:0] {
    REQ_IDLE   = 6'h01,
    REQ_STROBE = 6'h02,
    REQ_OPEN   = 6'h04,
    REQ_BURST  = 6'h08,
    REQ_CASPRE = 6'h10,
    REQ_END    = 6'h20
  } req_state_e;

endpackage

// file: core/drc_if.sv
// Purpose: processor-side link between requester and dram controller
// Assumes: both ends on clock_i
// Notes: all signals are plain one-way wires
`timescale 1ns/10ps
`default_nettype none
interface drc_if #(
  parameter int ADDR_W = 22,
  parameter int NUM_BANKS = 4
) ();
  logic access_request_n;
  logic chip_select_n;
  logic addr_latch;
  logic addr_strobe_n;
  logic [ADDR_W-1:0] addr;
  logic write_n;
  logic column_increment;
  logic [NUM_BANKS-1:0] cas_enable_n;
  logic wait_n;
  logic refresh_request_out;

  modport dev (
    input access_request_n, chip_select_n, addr_latch, addr_strobe_n, addr, write_n,
    input column_increment, cas_enable_n,
    output wait_n, refresh_request_out
  );
  modport host (
    output access_request_n, chip_select_n, addr_latch, addr_strobe_n, addr, write_n,
    output column_increment, cas_enable_n,
    input wait_n, refresh_request_out
  );
endinterface
`default_nettype wire

// file: core/bank_precharge_counter.sv
// Purpose: ras precharge timer of one bank
// Assumes: start_i pulses on the edge at which the bank's ras rises
// Notes: busy_o stays high until the programmed count has elapsed
`timescale 1ns/10ps
`default_nettype none
module bank_precharge_counter (
  input wire logic clock_i,         // system clock
  input wire logic sys_rst_i,       // sync reset, high
  input wire logic start_i,         // ras of this bank released
  input wire logic [2:0] target_i,  // programmed precharge cycles
  output logic busy_o               // bank still precharging
);
  logic [2:0] cnt_q;
  logic busy_q;

  // release edge itself counts as 1T
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
    end else if (start_i) begin
      cnt_q <= 3'h1;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q >= target_i) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  assign busy_o = busy_q;
endmodule
`default_nettype wire

// file: core/dram_requester.sv
// Purpose: processor-side requester driving the dram controller link
// Assumes: async_mode_select_i equals the controller's setting
// Notes: column steps use the increment input only
`timescale 1ns/10ps
`default_nettype none
`include "drc_params.svh"
module dram_requester #(
  parameter int ADDR_W = 22,
  parameter int NUM_BANKS = 4
) (
  input wire logic clock_i,               // system clock
  input wire logic sys_rst_i,             // sync reset, high
  drc_if.host bus,                        // controller side
  input wire logic async_mode_select_i,   // 0 latch pulse, 1 strobe
  input wire logic cmd_valid_i,           // command offered
  input wire logic cmd_write_i,           // 1 write, 0 read
  input wire logic [ADDR_W-1:0] cmd_addr_i, // {row, column, bank}
  input wire logic [7:0] cmd_beats_i,     // extra column steps
  output logic cmd_ready_o,               // command taken when valid
  output logic cmd_done_o                 // access finished, one cycle
);
  drc_pkg::req_state_e state_q;
  logic access_request_n_n_q;
  logic cs_n_q;
  logic latch_q;
  logic strobe_n_q;
  logic column_increment_q;
  logic [NUM_BANKS-1:0] cas_en_n_q;
  logic [ADDR_W-1:0] addr_q;
  logic write_n_q;
  logic [7:0] beats_q;
  logic [9:0] rcnt_q;
  logic done_q;

  // refresh pending: take no new command
  assign cmd_ready_o = (state_q == drc_pkg::REQ_IDLE) && !bus.refresh_request_out;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || state_q == drc_pkg::REQ_IDLE) begin
      rcnt_q <= 10'h0;
    end else if (rcnt_q != 10'h3ff) begin
      rcnt_q <= rcnt_q + 10'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= drc_pkg::REQ_IDLE;
      access_request_n_n_q <= 1'b1;
      cs_n_q <= 1'b1;
      latch_q <= 1'b0;
      strobe_n_q <= 1'b1;
      column_increment_q <= 1'b0;
      cas_en_n_q <= '1;
      addr_q <= '0;
      write_n_q <= 1'b1;
      beats_q <= 8'h0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      latch_q <= 1'b0;
      column_increment_q <= 1'b0;
      case (state_q)
        drc_pkg::REQ_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            addr_q <= cmd_addr_i;
            write_n_q <= ~cmd_write_i;
            beats_q <= cmd_beats_i;
            access_request_n_n_q <= 1'b0;
            cs_n_q <= 1'b0;
            latch_q <= ~async_mode_select_i;
            strobe_n_q <= ~async_mode_select_i;
            state_q <= drc_pkg::REQ_STROBE;
          end
        end
        drc_pkg::REQ_STROBE: begin
          cas_en_n_q <= '0;
          state_q <= drc_pkg::REQ_OPEN;
        end
        drc_pkg::REQ_OPEN: begin
          // chip select dropped once the row is open, so no later
          // strobe edge could open a second row
          if (bus.wait_n && rcnt_q > 10'h2) begin
            cs_n_q <= 1'b1;
            state_q <= drc_pkg::REQ_BURST;
          end
        end
        drc_pkg::REQ_BURST: begin
          if (beats_q == 8'h0 || rcnt_q >= 10'(`DRC_MAX_RAS_LOW_CYC)) begin
            state_q <= drc_pkg::REQ_END;
          end else begin
            column_increment_q <= 1'b1;
            addr_q <= addr_q + ADDR_W'(1 << `DRC_COL_LSB);
            beats_q <= beats_q - 8'h1;
            cas_en_n_q <= '1;
            state_q <= drc_pkg::REQ_CASPRE;
          end
        end
        drc_pkg::REQ_CASPRE: begin
          cas_en_n_q <= '0;
          state_q <= drc_pkg::REQ_BURST;
        end
        drc_pkg::REQ_END: begin
          if (rcnt_q >= 10'(`DRC_MIN_RAS_LOW_CYC)) begin
            access_request_n_n_q <= 1'b1;
            cs_n_q <= 1'b1;
            strobe_n_q <= 1'b1;
            cas_en_n_q <= '1;
            done_q <= 1'b1;
            state_q <= drc_pkg::REQ_IDLE;
          end
        end
        default: begin
          state_q <= drc_pkg::REQ_IDLE;
        end
      endcase
    end
  end

  assign bus.access_request_n = access_request_n_n_q;
  assign bus.chip_select_n = cs_n_q;
  assign bus.addr_latch = latch_q;
  assign bus.addr_strobe_n = strobe_n_q;
  assign bus.addr = addr_q;
  assign bus.write_n = write_n_q;
  assign bus.column_increment = column_increment_q;
  assign bus.cas_enable_n = cas_en_n_q;
  assign cmd_done_o = done_q;
endmodule
`default_nettype wire

// file: test/dram_access_precharge_ctrl_assertions.sv
// Purpose: timing checks on the link and dram strobes
// Assumes: four banks; precharge target is field plus two
// Notes: gap check allows one cycle of slack
`timescale 1ns/10ps
`default_nettype none
module dram_access_precharge_ctrl_assertions (
  input wire logic clock_i,                   // clock
  input wire logic sys_rst_i,                 // reset
  input wire logic access_request_n,          // access held
  input wire logic write_n,                   // write, low
  input wire logic [3:0] cas_enable_n,        // cas gates
  input wire logic wait_n,                    // wait, low
  input wire logic refresh_request_out,       // refresh pending
  input wire logic refresh_tick_i,            // refresh tick
  input wire logic write_cas_delay_select_i,  // cas delay
  input wire logic precharge_count_sel_lo_i,  // field bit 0
  input wire logic precharge_count_sel_hi_i,  // field bit 1
  input wire logic [3:0] ras_n_o,             // row strobes
  input wire logic [3:0] cas_n_o              // column strobes
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic [3:0] high_cnt_q [4];
  logic [3:0] target;
  assign target = 4'h2 + {2'h0, precharge_count_sel_hi_i, precharge_count_sel_lo_i};
  // starts full so a bank is usable straight after reset
  always_ff @(posedge clock_i) begin
    for (int b = 0; b < 4; b++) begin
      if (sys_rst_i) begin
        high_cnt_q[b] <= 4'hf;
      end else if (!ras_n_o[b]) begin
        high_cnt_q[b] <= 4'h0;
      end else if (high_cnt_q[b] != 4'hf) begin
        high_cnt_q[b] <= high_cnt_q[b] + 4'h1;
      end
    end
  end
  for (genvar g = 0; g < 4; g++) begin : gap
    a_precharge_gap: assert property ($fell(ras_n_o[g]) |-> high_cnt_q[g] >= target)
      else $error("bank reopened too early");
  end
  a_cas_follows_enable: assert property ((cas_n_o | ~cas_enable_n) == 4'hf)
    else $error("cas low without enable");
  a_reset_idle: assert property (disable iff (1'b0) sys_rst_i |=> ras_n_o == 4'hf && wait_n)
    else $error("strobes not idle after reset");
  a_refresh_sets: assert property (refresh_tick_i |=> refresh_request_out)
    else $error("tick lost");
  a_refresh_after_release: assert property (ras_n_o == 4'h0 && $past(ras_n_o) != 4'h0 |->
    $past(access_request_n) && $past(ras_n_o) == 4'hf)
    else $error("refresh during access");
  a_ras_held: assert property (!access_request_n && ras_n_o != 4'hf && ras_n_o != 4'h0 |=> $stable(ras_n_o))
    else $error("ras moved while request held");
  a_ras_release: assert property (access_request_n && ras_n_o != 4'hf && ras_n_o != 4'h0 |=> ras_n_o == 4'hf)
    else $error("ras not released");
  a_one_bank: assert property (ras_n_o != 4'h0 |-> $countones(~ras_n_o) <= 1)
    else $error("two banks open");
  a_write_delay: assert property ($rose(wait_n) && !write_n && write_cas_delay_select_i |-> cas_n_o == 4'hf)
    else $error("write cas not delayed");
  c_refresh: cover property (ras_n_o == 4'h0);
  c_cas: cover property (cas_n_o != 4'hf);
  c_wait: cover property (!wait_n && ras_n_o == 4'hf);
endmodule
`default_nettype wire

// file: test/dram_access_precharge_ctrl_test.sv
// Purpose: self-checking bench of requester and controller
// Assumes: second controller driven by hand in strobe mode
// Notes: mode bits change only with a settle gap
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t %s", $time, m); end end
module dram_access_precharge_ctrl_test;
  typedef struct packed {
    logic wr, am, rh, cs, wcd;
    logic [1:0] pf;
    logic [9:0] r, c;
    logic [1:0] b;
    logic [7:0] beats;
    logic [2:0] nwait;
  } row_s;
  row_s rows [6] = '{
    '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 10'h155, 10'h004, 2'h0, 8'h02, 3'h3},
    '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'h1, 10'h2aa, 10'h010, 2'h1, 8'h00, 3'h4},
    '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h1, 10'h001, 10'h3f0, 2'h1, 8'h01, 3'h4},
    '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 2'h3, 10'h3ff, 10'h3ff, 2'h2, 8'h00, 3'h4},
    '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 2'h3, 10'h200, 10'h000, 2'h2, 8'h03, 3'h4},
    '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h2, 10'h0f0, 10'h123, 2'h3, 8'h01, 3'h3}};
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic col_sel = 1'b0, row_sel = 1'b0, wcd_sel = 1'b0, amode = 1'b0, tick = 1'b0;
  logic [1:0] pf = 2'h0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, cmd_done;
  logic [21:0] cmd_addr = 22'h0;
  logic [7:0] cmd_beats = 8'h0;
  logic [3:0] ras_n, cas_n, ras2_n, cas2_n;
  logic we_n;
  logic [9:0] da, da2;
  int error_cnt = 0, checks = 0, cyc = 0, wt, rc;
  drc_if link ();
  drc_if link2 ();
  dram_ctrl_unit dram_ctrl_unit_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus(link.dev),
    .col_setup_select_i(col_sel), .row_hold_select_i(row_sel), .write_cas_delay_select_i(wcd_sel),
    .precharge_count_sel_lo_i(pf[0]), .precharge_count_sel_hi_i(pf[1]), .async_mode_select_i(amode),
    .refresh_tick_i(tick), .ras_n_o(ras_n), .cas_n_o(cas_n), .dram_addr_o(da), .dram_we_n_o(we_n));
  dram_ctrl_unit dram_ctrl_unit_i2 (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus(link2.dev),
    .col_setup_select_i(col_sel), .row_hold_select_i(row_sel), .write_cas_delay_select_i(wcd_sel),
    .precharge_count_sel_lo_i(pf[0]), .precharge_count_sel_hi_i(pf[1]), .async_mode_select_i(1'b1),
    .refresh_tick_i(1'b0), .ras_n_o(ras2_n), .cas_n_o(cas2_n), .dram_addr_o(da2), .dram_we_n_o());
  dram_requester dram_requester_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus(link.host),
    .async_mode_select_i(amode), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr),
    .cmd_beats_i(cmd_beats), .cmd_ready_o(cmd_ready), .cmd_done_o(cmd_done));
  dram_access_precharge_ctrl_assertions dram_access_precharge_ctrl_assertions_i (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .access_request_n(link.access_request_n), .write_n(link.write_n),
    .cas_enable_n(link.cas_enable_n), .wait_n(link.wait_n), .refresh_request_out(link.refresh_request_out),
    .refresh_tick_i(tick), .write_cas_delay_select_i(wcd_sel), .precharge_count_sel_lo_i(pf[0]),
    .precharge_count_sel_hi_i(pf[1]), .ras_n_o(ras_n), .cas_n_o(cas_n));
  initial forever #5 clock_i = ~clock_i;
  task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end
  task automatic run_cmd(input row_s x);
    int n;
    int nw;
    logic [3:0] pr;
    logic [3:0] pc;
    logic [9:0] cols [$];
    n = 0;
    nw = 0;
    @(negedge clock_i);
    // mode bits must be static while a bank is busy; here they change during the last bank's precharge
    if ({amode, row_sel, col_sel, wcd_sel, pf} != {x.am, x.rh, x.cs, x.wcd, x.pf}) begin
      {amode, row_sel, col_sel, wcd_sel, pf} = {x.am, x.rh, x.cs, x.wcd, x.pf};
      repeat (8) @(negedge clock_i);
    end
    {cmd_write, cmd_addr, cmd_beats, cmd_valid} = {x.wr, x.r, x.c, x.b, x.beats, 1'b1};
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    pr = ras_n;
    pc = cas_n;
    @(negedge clock_i);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < 300) begin
      if (pr[x.b] && !ras_n[x.b] && ras_n != 4'h0) begin
        `CHK(ras_n, ~(4'h1 << x.b), "wrong bank")
        `CHK(da, x.r, "row address")
      end
      if (!ras_n[x.b] && ras_n != 4'h0 && link.wait_n === 1'b0) nw++;
      if (pc[x.b] && !cas_n[x.b]) begin
        cols.push_back(da);
        `CHK(we_n, ~x.wr, "write enable at cas")
      end
      pr = ras_n;
      pc = cas_n;
      @(negedge clock_i);
      n++;
    end
    `CHK(cmd_done, 1'b1, "no done")
    `CHK(nw, int'(x.nwait), "row hold and setup wait")
    `CHK(cols.size(), int'(x.beats) + 1, "column count")
    for (int i = 0; i <= x.beats; i++) begin
      `CHK(cols[i], x.c + 10'(i), "column step")
    end
  endtask
  initial begin
    {link2.access_request_n, link2.chip_select_n, link2.addr_latch} = 3'b110;
    {link2.addr_strobe_n, link2.write_n, link2.column_increment} = 3'b110;
    link2.addr = 22'h0;
    link2.cas_enable_n = 4'hf;
    rc = 0;
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 6; i++) begin
      run_cmd(rows[i]);
      $display("row %0d finished", i);
    end
    fork
      run_cmd(rows[0]);
      begin
        repeat (12) @(negedge clock_i);
        tick = 1'b1;
        @(negedge clock_i);
        tick = 1'b0;
        `CHK(link.refresh_request_out, 1'b1, "refresh not pending")
        `CHK(cmd_ready, 1'b0, "ready while refresh pending")
      end
      repeat (80) begin
        @(negedge clock_i);
        if (ras_n === 4'h0) rc++;
      end
    join
    `CHK(rc, 4, "refresh length")
    `CHK(link.refresh_request_out, 1'b0, "refresh stuck")
    $display("refresh test finished");
    {cmd_addr, cmd_valid} = {rows[3].r, rows[3].c, rows[3].b, 1'b1};
    repeat (6) @(negedge clock_i);
    {cmd_valid, sys_rst_i} = 2'b01;
    @(negedge clock_i);
    `CHK(ras_n, 4'hf, "ras after reset")
    `CHK(link.wait_n, 1'b1, "wait after reset")
    `CHK(cmd_ready, 1'b1, "ready after reset")
    sys_rst_i = 1'b0;
    run_cmd(rows[5]);
    $display("reset test finished");
    link2.addr = {10'h123, 10'h045, 2'h1};
    {link2.chip_select_n, link2.access_request_n} = 2'b00;
    @(negedge clock_i);
    link2.addr_strobe_n = 1'b0;
    @(negedge clock_i);
    wt = 0;
    while (link2.wait_n !== 1'b1 && wt < 30) begin
      @(negedge clock_i);
      wt++;
    end
    `CHK(cas2_n, 4'hf, "cas without enable")
    link2.cas_enable_n = 4'hd;
    @(negedge clock_i);
    `CHK(cas2_n, 4'hd, "cas not following enable")
    `CHK(da2, 10'h045, "strobe column")
    {link2.cas_enable_n, link2.chip_select_n, link2.addr_strobe_n} = 6'h3f;
    link2.addr = {10'h321, 10'h2a7, 2'h1};
    @(negedge clock_i);
    link2.addr_strobe_n = 1'b0;
    repeat (3) @(negedge clock_i);
    `CHK(ras2_n, 4'hd, "row reopened")
    `CHK(da2, 10'h2a7, "new column")
    {link2.access_request_n, link2.addr_strobe_n} = 2'b11;
    link2.addr = ~link2.addr;
    repeat (10) @(negedge clock_i);
    `CHK(ras2_n, 4'hf, "ras not released")
    $display("column strobe test finished");
    results();
  end
endmodule
`default_nettype wire
